// ===== torque_off_pkg.sv
/*
 * Shared constants for the torque-off restart control block:
 * register offsets, field positions, mode selector codes and event codes.
 * Assumes a 32-bit APB register bus and a single system clock.
 */
package torque_off_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESET = 8'h08;

    // ----------------------------------------------------------------
    // mode selector codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_ALARM = 4'h1;
    localparam logic [3:0] MODE_WARNING = 4'h3;
    localparam logic [3:0] MODE_THERM_ALARM = 4'h4;
    localparam logic [3:0] MODE_THERM_WARNING = 4'h5;
    localparam logic [3:0] MODE_COMB_ALARM = 4'h6;
    localparam logic [3:0] MODE_COMB_WARNING = 4'h7;
    localparam logic [3:0] MODE_COMB_ALARM_WARNING = 4'h8;
    localparam logic [3:0] MODE_COMB_WARNING_ALARM = 4'h9;
    localparam logic [3:0] MODE_RESET = MODE_ALARM;
    localparam int MODE_W = 4;

    // ----------------------------------------------------------------
    // event codes and status field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] EVT_NONE = 8'h00;
    localparam logic [7:0] EVT_SAFE_STOP = 8'h44;
    localparam logic [7:0] EVT_DANGER = 8'h48;
    localparam int ST_TORQUE_OFF = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_WARNING = 2;
    localparam int ST_INPUT_OK = 3;
    localparam int ST_THERM_TRIP = 4;
    localparam int ST_EVT_LSB = 8;
    localparam int RESET_BIT = 0;

    typedef enum logic [1:0] {ST_RUN, ST_OFF_AUTO, ST_OFF_LATCH} stop_state_t;

endpackage

// ===== stop_if.sv
/*
 * Carries conditioned safety levels and the reset pulse from the input
 * conditioner to the restart controller. Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface stop_if;
    logic stop_ok;
    logic therm_trip;
    logic reset_pulse;
    modport src (output stop_ok, output therm_trip, output reset_pulse);
    modport snk (input stop_ok, input therm_trip, input reset_pulse);
endinterface
`default_nettype wire

// ===== stop_input_cond.sv
/*
 * Input conditioner: synchronises the safe-stop level, the thermistor
 * trip level and the reset sources (digital input, panel key).
 * Assumes pins may change at any time relative to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module stop_input_cond #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic safe_stop_in,
    input wire logic therm_trip_in,
    input wire logic reset_din,
    input wire logic reset_key,
    stop_if.src cond
);
    logic [SYNC_STAGES-1:0] stop_sync_reg;
    logic [SYNC_STAGES-1:0] therm_sync_reg;
    logic [SYNC_STAGES-1:0] rst_sync_reg;
    logic rst_seen_reg;

    // elaboration check: a synchroniser needs at least two flops
    if (SYNC_STAGES < 2)
    begin : g_bad_stages
        $error("stop_input_cond: SYNC_STAGES must be at least 2");
    end

    // synchronisers; reset holds the input in the safe (stopped) level
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stop_sync_reg <= '0;
            therm_sync_reg <= '0;
            rst_sync_reg <= '0;
        end
        else
        begin
            stop_sync_reg <= {stop_sync_reg[SYNC_STAGES-2:0], safe_stop_in};
            therm_sync_reg <= {therm_sync_reg[SYNC_STAGES-2:0], therm_trip_in};
            rst_sync_reg <= {rst_sync_reg[SYNC_STAGES-2:0],
                             reset_din | reset_key};
        end
    end

    // last-stage copy for reset edge detection
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rst_seen_reg <= 1'b0;
        else
            rst_seen_reg <= rst_sync_reg[SYNC_STAGES-1];
    end

    // no filtering: one low sample counts as a stop request
    assign cond.stop_ok = stop_sync_reg[SYNC_STAGES-1];
    assign cond.therm_trip = therm_sync_reg[SYNC_STAGES-1];
    assign cond.reset_pulse = rst_sync_reg[SYNC_STAGES-1] & ~rst_seen_reg;

endmodule
`default_nettype wire

// ===== torque_off_ctrl.sv
/*
 * Torque-off restart control with APB register access.
 * Assumes an external AND of thermistor card output and safety sensor
 * drives safe_stop_in, and the card reports its own trip on therm_trip_in.
 */
// Contract
// - Removing the safe-stop input voltage alone forces torque off.
// - Alarm mode raises alarm, trips the drive, motor coasts uncontrolled.
// - Manual restart needs input restored first, then bus, input or key reset.
// - Mode defaults to alarm; warning mode resumes when voltage returns.
// - Modes four to nine accepted only with thermistor card fitted.
// - Alarm or warning mode plus card trip gives failure 72, no auto restart.
// - Thermistor-only mode plus external trip gives failure 72, no auto restart.
// - Modes six to nine combine card and relay; seven, eight restart automatically.
// - Torque off is a category zero stop: power removed at once.
// - Safe stop reports code 68: alarm if manual, warning if automatic.
`timescale 1ns/1ps
`default_nettype none
module torque_off_ctrl
    import torque_off_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic safe_stop_in,
    input wire logic therm_trip_in,
    input wire logic card_fitted,
    input wire logic reset_din,
    input wire logic reset_key,
    output logic torque_off,
    output logic drive_trip,
    output logic alarm,
    output logic warning,
    output logic [7:0] event_code
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    stop_if cond ();
    stop_state_t state_reg;
    stop_state_t state_next;
    logic [MODE_W-1:0] mode_reg;
    logic [7:0] event_reg;
    logic [7:0] event_next;
    logic torque_off_reg;
    logic [31:0] prdata_reg;
    logic stop_low;
    logic fault72;
    logic manual_mode;
    logic any_reset;
    logic wr_access;
    logic bus_reset;
    logic mode_legal;
    logic addr_ok;

    stop_input_cond #(
        .SYNC_STAGES(SYNC_STAGES)
    ) u_cond (
        .clk_sys(clk_sys),
        .rst(rst),
        .safe_stop_in(safe_stop_in),
        .therm_trip_in(therm_trip_in),
        .reset_din(reset_din),
        .reset_key(reset_key),
        .cond(cond.src)
    );

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // address decode and mode legality
    always_comb
    begin
        addr_ok = (paddr == OFS_MODE) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_RESET);
        unique case (pwdata[MODE_W-1:0])
            MODE_ALARM, MODE_WARNING:
                mode_legal = 1'b1;
            MODE_THERM_ALARM, MODE_THERM_WARNING, MODE_COMB_ALARM,
            MODE_COMB_WARNING, MODE_COMB_ALARM_WARNING,
            MODE_COMB_WARNING_ALARM:
                mode_legal = card_fitted;
            default:
                mode_legal = 1'b0;
        endcase
    end

    // zero-wait access; errors on unmapped address or refused mode
    assign pready = psel & penable;
    assign wr_access = psel & penable & pwrite;
    assign pslverr = pready & (~addr_ok | (pwrite & (paddr == OFS_MODE) &
                               ~mode_legal));
    assign bus_reset = wr_access & (paddr == OFS_RESET) & pwdata[RESET_BIT];
    assign prdata = prdata_reg;

    // mode selector register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            mode_reg <= MODE_RESET;
        else if (wr_access && paddr == OFS_MODE && mode_legal)
            mode_reg <= pwdata[MODE_W-1:0];
    end

    // read data captured in the setup phase
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prdata_reg <= '0;
        else if (psel && !penable)
        begin
            prdata_reg <= '0;
            if (paddr == OFS_MODE)
                prdata_reg[MODE_W-1:0] <= mode_reg;
            else if (paddr == OFS_STATUS)
            begin
                prdata_reg[ST_TORQUE_OFF] <= torque_off_reg;
                prdata_reg[ST_ALARM] <= state_reg == ST_OFF_LATCH;
                prdata_reg[ST_WARNING] <= state_reg == ST_OFF_AUTO;
                prdata_reg[ST_INPUT_OK] <= cond.stop_ok;
                prdata_reg[ST_THERM_TRIP] <= cond.therm_trip;
                prdata_reg[ST_EVT_LSB +: 8] <= event_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // stop classification
    // ----------------------------------------------------------------
    assign stop_low = ~cond.stop_ok;
    assign any_reset = cond.reset_pulse | bus_reset;

    // mismatched source for the selected mode and restart style
    always_comb
    begin
        fault72 = 1'b0;
        manual_mode = 1'b1;
        unique case (mode_reg)
            MODE_ALARM:
                fault72 = stop_low & cond.therm_trip;
            MODE_WARNING:
            begin
                fault72 = stop_low & cond.therm_trip;
                manual_mode = 1'b0;
            end
            MODE_THERM_ALARM:
                fault72 = stop_low & ~cond.therm_trip;
            MODE_THERM_WARNING:
            begin
                fault72 = stop_low & ~cond.therm_trip;
                manual_mode = 1'b0;
            end
            MODE_COMB_WARNING, MODE_COMB_ALARM_WARNING:
                manual_mode = 1'b0;
            default:
                manual_mode = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // restart state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        event_next = event_reg;
        unique case (state_reg)
            ST_RUN:
                if (stop_low)
                begin
                    if (fault72 || manual_mode)
                        state_next = ST_OFF_LATCH;
                    else
                        state_next = ST_OFF_AUTO;
                    event_next = fault72 ? EVT_DANGER : EVT_SAFE_STOP;
                end
            ST_OFF_AUTO:
                if (fault72)
                begin
                    state_next = ST_OFF_LATCH;
                    event_next = EVT_DANGER;
                end
                else if (!stop_low)
                begin
                    state_next = ST_RUN;
                    event_next = EVT_NONE;
                end
            ST_OFF_LATCH:
                if (fault72)
                    event_next = EVT_DANGER;
                else if (!stop_low && any_reset)
                begin
                    state_next = ST_RUN;
                    event_next = EVT_NONE;
                end
        endcase
    end

    // state and event registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= ST_OFF_LATCH;
            event_reg <= EVT_NONE;
        end
        else
        begin
            state_reg <= state_next;
            event_reg <= event_next;
        end
    end

    // power removal follows the stop decision at once, no ramp
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            torque_off_reg <= 1'b1;
        else
            torque_off_reg <= state_next != ST_RUN;
    end

    // indicator outputs
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            alarm <= 1'b0;
            warning <= 1'b0;
        end
        else
        begin
            alarm <= state_next == ST_OFF_LATCH && event_next != EVT_NONE;
            warning <= state_next == ST_OFF_AUTO;
        end
    end

    assign torque_off = torque_off_reg;
    assign drive_trip = alarm;
    assign event_code = event_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_low_stops: assert property (stop_low |=> torque_off)
        else $error("low input did not remove torque");
    chk_alarm_trip: assert property (
        $rose(alarm) |-> drive_trip && torque_off)
        else $error("alarm without trip and coast");
    chk_hold_low: assert property (
        state_reg == ST_OFF_LATCH && stop_low |=> state_reg == ST_OFF_LATCH)
        else $error("latched stop left while input low");
    chk_reset_needed: assert property (
        $past(state_reg) == ST_OFF_LATCH && state_reg == ST_RUN
        |-> $past(any_reset) && $past(cond.stop_ok))
        else $error("manual restart without reset");
    chk_auto_resume: assert property (
        state_reg == ST_OFF_AUTO && !stop_low |=> !torque_off)
        else $error("warning mode did not resume");
    chk_mode_guard: assert property (
        $changed(mode_reg) && mode_reg >= MODE_THERM_ALARM
        |-> $past(card_fitted))
        else $error("extended mode taken without card");
    chk_fail_code: assert property (
        fault72 |=> event_code == EVT_DANGER && alarm && torque_off)
        else $error("dangerous failure not reported");
    chk_no_auto72: assert property (
        event_code == EVT_DANGER |-> state_reg == ST_OFF_LATCH)
        else $error("dangerous failure allows auto restart");
    chk_auto_modes: assert property (
        state_reg == ST_RUN && stop_low && !fault72 &&
        (mode_reg == MODE_COMB_WARNING || mode_reg == MODE_COMB_ALARM_WARNING)
        |=> state_reg == ST_OFF_AUTO)
        else $error("combined auto mode latched");
    chk_code_68: assert property (
        state_reg == ST_OFF_AUTO |-> event_code == EVT_SAFE_STOP)
        else $error("warning stop has wrong code");

    cov_manual: cover property (
        state_reg == ST_OFF_LATCH ##1 state_reg == ST_RUN);
    cov_auto: cover property (
        state_reg == ST_OFF_AUTO ##1 state_reg == ST_RUN);
    cov_danger: cover property ($rose(event_code == EVT_DANGER));
    cov_refused: cover property (pslverr);
endmodule
`default_nettype wire

// ===== safety_chain_model.sv
/*
 * Partner model: the external safety relay chain and thermistor card.
 * Assumes the bench moves the sensor and card levels just after an edge.
 */
`timescale 1ns/1ps
`default_nettype none
module safety_chain_model (
    input wire logic sensor_ok,
    input wire logic card_ok,
    output logic safe_stop_in,
    output logic therm_trip_in
);
    // safe AND of the card output and the safety sensor feeds the input
    assign safe_stop_in = sensor_ok & card_ok;
    // the card flags its own trip while its safe output is low
    assign therm_trip_in = ~card_ok;
endmodule
`default_nettype wire

// ===== safe_torque_off_restart_control_tb_top.sv
/*
 * Self-checking bench for the torque-off restart controller.
 * Assumes the design's default SYNC_STAGES of 2; the bus master waits
 * for pready, however long the slave takes.
 */
`timescale 1ns/1ps
`default_nettype none
module safe_torque_off_restart_control_tb_top;
    import torque_off_pkg::*;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic sensor_ok, card_ok, card_fitted, reset_din, reset_key;
    logic safe_stop_in, therm_trip_in;
    logic torque_off, drive_trip, alarm, warning;
    logic [7:0] event_code;
    int n_fail, num_checks, cyc;

    // ------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------
    torque_off_ctrl i_torque_off_ctrl (.clk_sys(clk_sys), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .safe_stop_in(safe_stop_in),
        .therm_trip_in(therm_trip_in), .card_fitted(card_fitted),
        .reset_din(reset_din), .reset_key(reset_key),
        .torque_off(torque_off), .drive_trip(drive_trip), .alarm(alarm),
        .warning(warning), .event_code(event_code));
    safety_chain_model i_safety_chain_model (.sensor_ok(sensor_ok),
        .card_ok(card_ok), .safe_stop_in(safe_stop_in),
        .therm_trip_in(therm_trip_in));

    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // a hang counts as a mismatch and ends the run
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // restart reset from the bus (0), the digital input (1) or the key (2)
    task automatic give_reset(input int src);
        if (src == 0)
            apb(1'b1, OFS_RESET, 32'h0000_0001);
        else
        begin
            @(posedge clk_sys);
            if (src == 1)
                reset_din <= 1'b1;
            else
                reset_key <= 1'b1;
            wait_cyc(4);
            reset_din <= 1'b0;
            reset_key <= 1'b0;
        end
        wait_cyc(5);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // manual restart: reset while input low is lost, reset after counts
    task automatic t_alarm_stop(input int src);
        apb(1'b1, OFS_MODE, {28'h0, MODE_ALARM});
        sensor_ok <= 1'b0;
        wait_cyc(5);
        chk(torque_off, 1'b1);
        chk({alarm, drive_trip, warning}, 3'b110);
        chk(event_code, EVT_SAFE_STOP);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({rdata[15:8], rdata[0]}, {EVT_SAFE_STOP, 1'b1});
        give_reset(src);
        sensor_ok <= 1'b1;
        wait_cyc(5);
        chk(torque_off, 1'b1);
        give_reset(src);
        chk({torque_off, alarm, event_code}, 10'h000);
    endtask

    // warning option restarts as soon as the voltage returns
    task automatic t_warning_stop();
        apb(1'b1, OFS_MODE, {28'h0, MODE_WARNING});
        sensor_ok <= 1'b0;
        wait_cyc(5);
        chk({torque_off, alarm, warning, drive_trip}, 4'b1010);
        chk(event_code, EVT_SAFE_STOP);
        sensor_ok <= 1'b1;
        wait_cyc(5);
        chk({torque_off, warning}, 2'b00);
    endtask

    // extended options need the card; bad codes and holes are refused
    task automatic t_mode_gate();
        card_fitted <= 1'b0;
        for (int m = 4; m <= 9; m++)
        begin
            apb(1'b1, OFS_MODE, m);
            chk(err, 1'b1);
        end
        apb(1'b1, OFS_MODE, 32'h0000_0002);
        chk(err, 1'b1);
        apb(1'b0, OFS_MODE, 32'h0);
        chk(rdata[3:0], MODE_WARNING);
        card_fitted <= 1'b1;
        for (int m = 4; m <= 9; m++)
        begin
            apb(1'b1, OFS_MODE, m);
            chk(err, 1'b0);
            apb(1'b0, OFS_MODE, 32'h0);
            chk(rdata[3:0], m);
        end
        apb(1'b0, 8'h0C, 32'h0);
        chk(err, 1'b1);
        chk(rdata, 32'h0);
    endtask

    // one low sample while running in alarm mode must still latch a stop
    task automatic t_glitch();
        sensor_ok <= 1'b0;
        wait_cyc(1);
        sensor_ok <= 1'b1;
        wait_cyc(5);
        chk({torque_off, alarm}, 2'b11);
        give_reset(0);
        chk(torque_off, 1'b0);
    endtask

    // dangerous failure: latched, event 72, only a reset clears it
    task automatic t_danger(input logic [3:0] mode, input logic card);
        apb(1'b1, OFS_MODE, {28'h0, mode});
        if (card)
            card_ok <= 1'b0;
        else
            sensor_ok <= 1'b0;
        wait_cyc(5);
        chk({torque_off, alarm, event_code}, {2'b11, EVT_DANGER});
        card_ok <= 1'b1;
        sensor_ok <= 1'b1;
        wait_cyc(5);
        chk(torque_off, 1'b1);
        give_reset(0);
        chk(torque_off, 1'b0);
    endtask

    // thermistor-only options with a card trip and combined options with a
    // sensor trip; five, seven and eight restart on their own
    task automatic t_combined();
        for (int m = 4; m <= 9; m++)
        begin
            apb(1'b1, OFS_MODE, m);
            if (m < 6)
                card_ok <= 1'b0;
            else
                sensor_ok <= 1'b0;
            wait_cyc(5);
            chk({torque_off, event_code}, {1'b1, EVT_SAFE_STOP});
            card_ok <= 1'b1;
            sensor_ok <= 1'b1;
            wait_cyc(5);
            chk(torque_off, !(m == 5 || m == 7 || m == 8));
            give_reset(0);
            chk(torque_off, 1'b0);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, reset_din, reset_key} = 5'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {rst, sensor_ok, card_ok, card_fitted} = 4'b1111;
        wait_cyc(2);
        rst <= 1'b0;
        wait_cyc(1);
        chk(torque_off, 1'b1);
        apb(1'b0, OFS_MODE, 32'h0);
        chk(rdata[3:0], MODE_ALARM);
        give_reset(0);
        chk(torque_off, 1'b0);
        for (int s = 0; s < 3; s++)
            t_alarm_stop(s);
        t_glitch();
        t_warning_stop();
        t_mode_gate();
        t_danger(MODE_WARNING, 1'b1);
        t_danger(MODE_ALARM, 1'b1);
        t_danger(MODE_THERM_ALARM, 1'b0);
        t_danger(MODE_THERM_WARNING, 1'b0);
        t_combined();
        report_and_stop();
    end
endmodule
`default_nettype wire
